// [hdl/sdtc_consts.svh]
// Constants of the SDRAM timing and clock-enable control block.
// Assumes inclusion by bare name from the block's design files.
`ifndef SDTC_CONSTS_SVH
`define SDTC_CONSTS_SVH
// Register offsets
`define SDTC_OFF_CTRL 8'h00
`define SDTC_OFF_STAT 8'h04
// Control register reset, writable bits (reserved ones read zero)
`define SDTC_CTRL_RST 32'h0000_0000
`define SDTC_CTRL_WMASK 32'h9fbe_ff7f
// Field positions
`define SDTC_POS_PD_SEL 18
`define SDTC_POS_CKE_ON 17
`define SDTC_POS_SR_LOW 13
`define SDTC_POS_ACT_RW 11
`define SDTC_POS_PRE_ACT 8
`define SDTC_POS_WR_REC 5
`define SDTC_POS_REF_REC 2
`define SDTC_POS_RD_LAT 0
// Timer load offsets: load value is cycles minus one
`define SDTC_RAS_ADD 4'h3
`define SDTC_WR_ADD 4'h1
// Latency codes that are allowed
`define SDTC_CL2 2'h1
`define SDTC_CL3 2'h2
// Pin commands {cs_n, ras_n, cas_n, we_n}
`define SDTC_CMD_NOP 4'h7
`define SDTC_CMD_ACT 4'h3
`define SDTC_CMD_READ 4'h5
`define SDTC_CMD_WRITE 4'h4
`define SDTC_CMD_PRE 4'h2
`define SDTC_CMD_REF 4'h1
// Timer indices
`define SDTC_TM_ARW 0
`define SDTC_TM_RP 1
`define SDTC_TM_WR 2
`define SDTC_TM_RC 3
`define SDTC_TM_RAS 4
`define SDTC_NT 5
`endif

// [hdl/sdtc_pkg.sv]
// Types of the SDRAM timing and clock-enable control block.
// Assumes nothing beyond a SystemVerilog compiler.
package sdtc_pkg;
  typedef enum logic [2:0] {
    SDTC_REQ_ACT = 3'h0,
    SDTC_REQ_READ = 3'h1,
    SDTC_REQ_WRITE = 3'h2,
    SDTC_REQ_PRE = 3'h3,
    SDTC_REQ_REF = 3'h4,
    SDTC_REQ_SREF_ENTER = 3'h5,
    SDTC_REQ_SREF_EXIT = 3'h6
  } sdtc_req_t;
  typedef enum logic [3:0] {
    SDTC_ST_OFF = 4'h1,
    SDTC_ST_IDLE = 4'h2,
    SDTC_ST_PDOWN = 4'h4,
    SDTC_ST_SREF = 4'h8
  } sdtc_state_t;
endpackage

// [hdl/sdtc_cfg_if.sv]
// Carrier between the register file and the command core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sdtc_cfg_if;
  logic cke_on;
  logic cke_set;
  logic pd_sel;
  logic [2:0] sr_low;
  logic [1:0] act_rw;
  logic [2:0] pre_act;
  logic [1:0] wr_rec;
  logic [2:0] ref_rec;
  logic [1:0] rd_lat;
  logic [7:0] status;
  modport regs(output cke_on, cke_set, pd_sel, sr_low, act_rw, pre_act, wr_rec, ref_rec, rd_lat,
    input status);
  modport core(input cke_on, cke_set, pd_sel, sr_low, act_rw, pre_act, wr_rec, ref_rec, rd_lat,
    output status);
endinterface

// [hdl/sdtc_timer.sv]
// Loadable down-counter guarding one command interval.
// Assumes load is a single-cycle request from the same clock.
`timescale 1ns/1ps
module sdtc_timer #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic busy
);
  logic [W-1:0] cnt;

  // Busy until the count has run out
  assign busy = (cnt != '0);

  // Reload wins over the running count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= value;
    end else if (busy) begin
      cnt <= cnt - 1'b1;
    end
  end
endmodule

// [hdl/sdtc_regs.sv]
// Control and status registers on a plain strobe port.
// Assumes strobes are one cycle long and never both at once.
`timescale 1ns/1ps
`include "sdtc_consts.svh"
module sdtc_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  sdtc_cfg_if.regs cfg
);
  logic [31:0] ctrl;
  logic cke_set;
  wire hit_ctrl = (addr == `SDTC_OFF_CTRL);
  wire hit_stat = (addr == `SDTC_OFF_STAT);
  wire wr_ctrl = wr & hit_ctrl;
  wire [31:0] rd_mux = hit_ctrl ? ctrl : hit_stat ? {24'h000000, cfg.status} : 32'h0000_0000;

  // Reserved bits are dropped on write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `SDTC_CTRL_RST;
      cke_set <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wdata & `SDTC_CTRL_WMASK;
      end
      cke_set <= wr_ctrl & wdata[`SDTC_POS_CKE_ON];
      rdata <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Field fan-out to the core
  assign cfg.cke_on = ctrl[`SDTC_POS_CKE_ON];
  assign cfg.cke_set = cke_set;
  assign cfg.pd_sel = ctrl[`SDTC_POS_PD_SEL];
  assign cfg.sr_low = ctrl[`SDTC_POS_SR_LOW +: 3];
  assign cfg.act_rw = ctrl[`SDTC_POS_ACT_RW +: 2];
  assign cfg.pre_act = ctrl[`SDTC_POS_PRE_ACT +: 3];
  assign cfg.wr_rec = ctrl[`SDTC_POS_WR_REC +: 2];
  assign cfg.ref_rec = ctrl[`SDTC_POS_REF_REC +: 3];
  assign cfg.rd_lat = ctrl[`SDTC_POS_RD_LAT +: 2];
endmodule

// [hdl/sdtc_top.sv]
// Command timing core of the SDRAM controller: clock-enable pin,
// power-down, self-refresh and the interval counters between commands.
// Assumes the request port and register port sit on clk, the SDRAM bus clock.
//
// Overview of operation
// - In power-down, only power-down exit is issued
// - Writing clock-enable bit one issues power-down exit
// - Clock-enable bit zero drives the pin low
// - Reserved control bits ignore writes, read zero
// - Self-refresh keeps clock-enable low 4 to 11
// - Activate to read or write: 1 to 4
// - Precharge to activate: field plus one cycles
// - Write recovery: field plus one cycles, held before activate, not before precharge
// - After write wait write-recovery plus precharge time
// - Refresh recovery blocks activate: 1 to 15
// - Self-refresh exit waits refresh recovery after pin
// - Read latency 2 or 3, other codes inhibited
// - Power-down mode enters power-down when idle
`timescale 1ns/1ps
`include "sdtc_consts.svh"
module sdtc_top #(
  parameter int TW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic req_valid,
  input wire sdtc_pkg::sdtc_req_t req_code,
  output logic req_grant,
  output logic sd_cke,
  output logic sd_clk_run,
  output logic [3:0] sd_cmd,
  output logic rd_sample
);

  sdtc_cfg_if cfg();

  // Register file on the strobe port
  sdtc_regs u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .cfg(cfg)
  );

  sdtc_pkg::sdtc_state_t state;
  sdtc_pkg::sdtc_state_t next_state;

  logic next_cke;
  logic next_clk_run;
  logic [3:0] next_cmd;
  logic next_grant;
  logic [2:0] pend;
  logic [2:0] next_pend;

  logic [`SDTC_NT-1:0] tm_load;
  logic [`SDTC_NT-1:0] tm_busy;
  logic [TW-1:0] tm_val [`SDTC_NT];

  // One down-counter per guarded interval
  generate
    for (genvar i = 0; i < `SDTC_NT; i++) begin : g_tm
      sdtc_timer #(
        .W(TW)
      ) u_tm (
        .clk(clk),
        .rst_n(rst_n),
        .load(tm_load[i]),
        .value(tm_val[i]),
        .busy(tm_busy[i])
      );
    end
  endgenerate

  // Load values are the cycle counts minus one
  assign tm_val[`SDTC_TM_ARW] = TW'({2'h0, cfg.act_rw});
  assign tm_val[`SDTC_TM_RP] = TW'({1'h0, cfg.pre_act});
  // Write recovery and precharge time are added
  assign tm_val[`SDTC_TM_WR] = TW'({2'h0, cfg.wr_rec}) + TW'({1'h0, cfg.pre_act})
                               + TW'(`SDTC_WR_ADD);
  // Odd counts 1 to 15 from the code
  assign tm_val[`SDTC_TM_RC] = TW'({cfg.ref_rec, 1'b0});
  // Low time 4 to 11 from the code
  assign tm_val[`SDTC_TM_RAS] = TW'({1'h0, cfg.sr_low}) + TW'(`SDTC_RAS_ADD);

  // Individual timer states
  wire arw_busy = tm_busy[`SDTC_TM_ARW];
  wire rp_busy = tm_busy[`SDTC_TM_RP];
  wire wr_busy = tm_busy[`SDTC_TM_WR];
  wire rc_busy = tm_busy[`SDTC_TM_RC];
  wire ras_busy = tm_busy[`SDTC_TM_RAS];
  wire any_busy = |tm_busy;

  // Latency code decode; inhibited codes stall reads
  wire cl_two = (cfg.rd_lat == `SDTC_CL2);
  wire cl_three = (cfg.rd_lat == `SDTC_CL3);
  wire cl_ok = cl_two | cl_three;

  // Refresh recovery also covers the wait after self-refresh exit,
  // so it holds back every command, not only activate
  wire quiet = ~rc_busy;

  // Per-request readiness
  wire act_ok = ~rp_busy & ~wr_busy;
  wire rw_ok = ~arw_busy;
  wire read_ok = rw_ok & cl_ok;
  wire ref_ok = ~rp_busy & ~wr_busy;
  wire sref_ok = ~rp_busy & ~wr_busy & (pend == 3'h0);

  // Request decode
  wire is_act = (req_code == sdtc_pkg::SDTC_REQ_ACT);
  wire is_read = (req_code == sdtc_pkg::SDTC_REQ_READ);
  wire is_write = (req_code == sdtc_pkg::SDTC_REQ_WRITE);
  wire is_pre = (req_code == sdtc_pkg::SDTC_REQ_PRE);
  wire is_ref = (req_code == sdtc_pkg::SDTC_REQ_REF);
  wire is_sin = (req_code == sdtc_pkg::SDTC_REQ_SREF_ENTER);
  wire is_sout = (req_code == sdtc_pkg::SDTC_REQ_SREF_EXIT);

  // Whether the request may go in this cycle from idle
  wire req_ok = (is_act & act_ok)
              | (is_read & read_ok)
              | (is_write & rw_ok)
              | is_pre
              | (is_ref & ref_ok)
              | (is_sin & sref_ok);

  // State flags
  wire in_off = (state == sdtc_pkg::SDTC_ST_OFF);
  wire in_idle = (state == sdtc_pkg::SDTC_ST_IDLE);
  wire in_pdown = (state == sdtc_pkg::SDTC_ST_PDOWN);
  wire in_sref = (state == sdtc_pkg::SDTC_ST_SREF);

  // A request taken from idle
  wire take = in_idle & req_valid & quiet & req_ok;

  // Kinds of taken request
  wire go_act = take & is_act;
  wire go_read = take & is_read;
  wire go_write = take & is_write;
  wire go_pre = take & is_pre;
  wire go_ref = take & is_ref;
  wire go_sin = take & is_sin;

  // Self-refresh exit once the low time has run out
  wire go_sout = in_sref & req_valid & is_sout & ~ras_busy;

  // Enter power-down only with nothing to do; a pending read
  // must land first, so the pipeline has to be empty
  wire pd_enter = in_idle & cfg.pd_sel & ~req_valid & ~any_busy
                & (pend == 3'h0) & ~cfg.cke_set;

  // Leave power-down on work, on mode off, or on software's write
  wire pd_exit = in_pdown & (req_valid | ~cfg.pd_sel | cfg.cke_set);

  // Timer loads
  assign tm_load[`SDTC_TM_ARW] = go_act;
  assign tm_load[`SDTC_TM_RP] = go_pre;
  assign tm_load[`SDTC_TM_WR] = go_write;
  assign tm_load[`SDTC_TM_RC] = go_ref | go_sout;
  assign tm_load[`SDTC_TM_RAS] = go_sin;

  // Read sample pipeline: a bit enters at depth latency minus one
  wire [2:0] pend_in = ~go_read ? 3'h0 : cl_three ? 3'h4 : 3'h2;
  assign next_pend = {1'b0, pend[2:1]} | pend_in;

  // Next pin state and command
  always_comb begin
    next_state = state;
    next_cke = sd_cke;
    next_clk_run = sd_clk_run;
    next_cmd = `SDTC_CMD_NOP;
    next_grant = 1'b0;
    unique case (state)
      sdtc_pkg::SDTC_ST_OFF: begin
        next_cke = 1'b0;
        // Pin raised once software has set the bit
        if (cfg.cke_set) begin
          next_cke = 1'b1;
          next_clk_run = 1'b1;
          next_state = sdtc_pkg::SDTC_ST_IDLE;
        end
      end
      sdtc_pkg::SDTC_ST_IDLE: begin
        if (pd_enter) begin
          next_cke = 1'b0;
          next_clk_run = 1'b0;
          next_state = sdtc_pkg::SDTC_ST_PDOWN;
        end else if (take) begin
          next_grant = 1'b1;
          if (go_act) begin
            next_cmd = `SDTC_CMD_ACT;
          end else if (go_read) begin
            next_cmd = `SDTC_CMD_READ;
          end else if (go_write) begin
            next_cmd = `SDTC_CMD_WRITE;
          end else if (go_pre) begin
            next_cmd = `SDTC_CMD_PRE;
          end else begin
            next_cmd = `SDTC_CMD_REF;
          end
          // Self-refresh: refresh with the pin dropped
          if (go_sin) begin
            next_cke = 1'b0;
            next_state = sdtc_pkg::SDTC_ST_SREF;
          end
        end
      end
      sdtc_pkg::SDTC_ST_PDOWN: begin
        // Nothing but the exit, or clearing the clock-enable bit, leaves here
        if (pd_exit) begin
          next_cke = 1'b1;
          next_clk_run = 1'b1;
          next_state = sdtc_pkg::SDTC_ST_IDLE;
        end
      end
      sdtc_pkg::SDTC_ST_SREF: begin
        if (go_sout) begin
          next_cke = 1'b1;
          next_grant = 1'b1;
          next_state = sdtc_pkg::SDTC_ST_IDLE;
        end
      end
      default: begin
        next_cke = 1'b0;
        next_clk_run = 1'b1;
        next_state = sdtc_pkg::SDTC_ST_OFF;
      end
    endcase
    // Clearing the bit drops the pin from any state
    if (!cfg.cke_on) begin
      next_cke = 1'b0;
      next_clk_run = 1'b1;
      next_cmd = `SDTC_CMD_NOP;
      next_grant = 1'b0;
      next_state = sdtc_pkg::SDTC_ST_OFF;
    end
  end

  // State and pin flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sdtc_pkg::SDTC_ST_OFF;
      sd_cke <= 1'b0;
      sd_clk_run <= 1'b1;
      sd_cmd <= `SDTC_CMD_NOP;
    end else begin
      state <= next_state;
      sd_cke <= next_cke;
      sd_clk_run <= next_clk_run;
      sd_cmd <= next_cmd;
    end
  end

  // Grant and read sample flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_grant <= 1'b0;
      pend <= 3'h0;
      rd_sample <= 1'b0;
    end else begin
      req_grant <= next_grant;
      pend <= next_pend;
      rd_sample <= pend[0];
    end
  end

  // Status for software: state, pin, timers, pending read
  assign cfg.status = {1'b0, |pend, any_busy, sd_cke,
                       in_sref, in_pdown, in_idle, in_off};

endmodule

// [sim/sdtc_sdram_model.sv]
// Observer model of the SDRAM chips on the command pins.
// Assumes pin commands are sampled on clk while the SDRAM clock runs.
`timescale 1ns/1ps
`include "sdtc_consts.svh"
module sdtc_sdram_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sd_clk_run,
  input wire logic [3:0] sd_cmd,
  output logic bad
);
  logic row_open;
  wire act = sd_cmd == `SDTC_CMD_ACT;
  wire pre = sd_cmd == `SDTC_CMD_PRE;
  wire data = sd_cmd == `SDTC_CMD_READ || sd_cmd == `SDTC_CMD_WRITE;
  // Data needs an open row; activate and refresh need it closed
  wire err = sd_clk_run && (row_open ? (act || sd_cmd == `SDTC_CMD_REF) : data);
  // Sticky flag, so one early slip is not lost in later traffic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      row_open <= 1'b0;
      bad <= 1'b0;
    end else begin
      bad <= bad | err;
      row_open <= act | (row_open & ~pre);
    end
  end
endmodule

// [sim/sdtc_top_chk.sv]
// Timing checker on the ports of the SDRAM timing control block.
// Assumes control writes take effect before the traffic they shape.
`timescale 1ns/1ps
`include "sdtc_consts.svh"
module sdtc_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic req_valid,
  input wire sdtc_pkg::sdtc_req_t req_code,
  input wire logic req_grant,
  input wire logic sd_cke,
  input wire logic sd_clk_run,
  input wire logic [3:0] sd_cmd,
  input wire logic rd_sample
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] ctl;
  logic [3:0] gap [5];
  wire [4:0] hit = {sd_cmd == `SDTC_CMD_REF && !sd_cke, sd_cmd == `SDTC_CMD_REF,
    sd_cmd == `SDTC_CMD_WRITE, sd_cmd == `SDTC_CMD_ACT, sd_cmd == `SDTC_CMD_PRE};
  wire act = sd_cmd == `SDTC_CMD_ACT;
  wire rdc = sd_cmd == `SDTC_CMD_READ;
  // Cycles since each guard command, saturating so idle time never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 32'h0;
      for (int i = 0; i < 5; i++) gap[i] <= 4'hf;
    end else begin
      if (wr && addr == 8'h00) ctl <= wdata;
      for (int i = 0; i < 5; i++) gap[i] <= hit[i] ? 4'h1 : gap[i] + 4'(gap[i] != 4'hf);
    end
  end
  a_cmd_has_grant: assert property (sd_cmd != `SDTC_CMD_NOP |-> req_grant)
    else $error("command without grant");
  a_pd_nop_only: assert property (!sd_clk_run |-> !sd_cke && sd_cmd == `SDTC_CMD_NOP)
    else $error("command in power-down");
  a_cke_clr_low: assert property (wr && addr == 8'h00 && !wdata[17] |-> ##2 !sd_cke)
    else $error("clock enable not low");
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read");
  a_rsvd_read_zero: assert property ($past(rd) && $past(addr) == 8'h00 |->
    (rdata & 32'h6041_0080) == 32'h0)
    else $error("reserved bit set");
  a_cl2_sample: assert property (rdc && ctl[1:0] == 2'h1 |-> ##2 rd_sample)
    else $error("latency two sample");
  a_cl3_sample: assert property (rdc && ctl[1:0] == 2'h2 |-> ##2 !rd_sample ##1 rd_sample)
    else $error("latency three sample");
  a_act_rw_gap: assert property (rdc || sd_cmd == `SDTC_CMD_WRITE |->
    5'(gap[1]) >= 5'(ctl[12:11]) + 5'h1)
    else $error("activate to access early");
  a_pre_act_gap: assert property (act |-> 5'(gap[0]) >= 5'(ctl[10:8]) + 5'h1)
    else $error("precharge to activate early");
  a_wr_act_gap: assert property (act || hit[3] |->
    5'(gap[2]) >= 5'(ctl[6:5]) + 5'(ctl[10:8]) + 5'h2)
    else $error("write recovery early");
  a_ref_act_gap: assert property (act |-> 5'(gap[3]) >= 5'(ctl[4:2]) * 5'h2 + 5'h1)
    else $error("refresh recovery early");
  a_sref_low: assert property ($rose(sd_cke) && req_grant |->
    5'(gap[4]) >= 5'(ctl[15:13]) + 5'h4)
    else $error("self-refresh exit early");
endmodule
bind sdtc_top sdtc_chk i_sdtc_chk (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .req_valid,
  .req_code, .req_grant, .sd_cke, .sd_clk_run, .sd_cmd, .rd_sample);

// [sim/tb_sdtc_top.sv]
// Self-checking bench for the SDRAM timing control block.
// Assumes the design, checker and SDRAM model are compiled first.
`timescale 1ns/1ps
module tb_sdtc_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic req_valid = 1'b0;
  sdtc_pkg::sdtc_req_t req_code = sdtc_pkg::SDTC_REQ_ACT;
  logic [31:0] rdata;
  logic req_grant, sd_cke, sd_clk_run, rd_sample, bad;
  logic [3:0] sd_cmd;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int t [15];
  int tx;
  // Request, pin command, guard entry and expected grant spacing
  logic [2:0] seq [15] = '{0, 1, 2, 3, 0, 3, 0, 3, 4, 0, 3, 5, 6, 0, 3};
  logic [3:0] ecmd [15] = '{3, 5, 4, 2, 3, 2, 3, 2, 1, 3, 2, 1, 7, 3, 2};
  int base [15] = '{0, 0, 0, 0, 2, 0, 5, 0, 7, 8, 0, 0, 11, 12, 0};
  int gap [15] = '{0, 4, 0, 0, 5, 0, 3, 0, 3, 3, 0, 0, 7, 3, 0};
  sdtc_top i_sdtc_top (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .req_valid,
    .req_code, .req_grant, .sd_cke, .sd_clk_run, .sd_cmd, .rd_sample);
  sdtc_sdram_model i_sdtc_sdram_model (.clk, .rst_n, .sd_clk_run, .sd_cmd, .bad);
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Hold the request until granted; a refused one is dropped after 40
  task automatic req(input logic [2:0] c, input bit want, input logic [3:0] e, output int g);
    g = -1;
    @(posedge clk);
    req_code <= sdtc_pkg::sdtc_req_t'(c);
    req_valid <= 1'b1;
    for (int i = 0; i < 40 && g < 0; i++) begin
      @(posedge clk);
      #1;
      if (req_grant === 1'b1) g = cyc;
    end
    req_valid <= 1'b0;
    if (g >= 0) chk({28'h0, sd_cmd}, {28'h0, e});
    if (want != (g >= 0)) begin
      chk(32'(g), 32'hffff_ffff);
      if (want) finish_test();
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk({29'h0, sd_cke, sd_clk_run, rd_sample}, 32'h2);
    chk({28'h0, sd_cmd}, 32'h7);
    rreg(8'h00, 32'h0);
    rreg(8'h08, 32'h0);
    rreg(8'h04, 32'h1);
    req(3'h0, 1'b0, 4'h7, tx);
    $display("test 1 finished");
    wreg(8'h00, 32'hffff_ffff);
    rreg(8'h00, 32'h9fbe_ff7f);
    wreg(8'h00, 32'h0);
    @(posedge clk);
    #1 chk({31'h0, sd_cke}, 32'h0);
    $display("test 2 finished");
    wreg(8'h00, 32'h0002_7a25);
    @(posedge clk);
    #1 chk({31'h0, sd_cke}, 32'h1);
    rreg(8'h04, 32'h12);
    for (int i = 0; i < 15; i++) begin
      req(seq[i], 1'b1, ecmd[i], t[i]);
      if (gap[i] > 0) chk(32'(t[i] - t[base[i]]), 32'(gap[i]));
    end
    $display("test 3 finished");
    wreg(8'h00, 32'h0002_7a26);
    req(3'h0, 1'b1, 4'h3, tx);
    req(3'h1, 1'b1, 4'h5, tx);
    req(3'h3, 1'b1, 4'h2, tx);
    wreg(8'h00, 32'h0002_7a24);
    req(3'h0, 1'b1, 4'h3, tx);
    req(3'h1, 1'b0, 4'h5, tx);
    req(3'h3, 1'b1, 4'h2, tx);
    $display("test 4 finished");
    wreg(8'h00, 32'h0006_7a24);
    repeat (4) @(posedge clk);
    #1 chk({30'h0, sd_cke, sd_clk_run}, 32'h0);
    rreg(8'h04, 32'h4);
    req(3'h0, 1'b1, 4'h3, tx);
    req(3'h3, 1'b1, 4'h2, tx);
    chk({31'h0, bad}, 32'h0);
    $display("test 5 finished");
    finish_test();
  end
endmodule
